// ==== common/ipr_pkg.sv ====
package ipr_pkg;

   // one 3-bit priority code: 0 disables, 1 lowest, 7 highest
   typedef logic [2:0] ipr_level_t;

   typedef struct packed {
      ipr_level_t serialEventLevel;
      ipr_level_t serialFaultLevel;
      ipr_level_t captureFiveLevel;
      ipr_level_t captureFourLevel;
      ipr_level_t captureThreeLevel;
   } ipr_levels_s;

   localparam int NUM_SOURCES = 5;

   // register byte offsets
   localparam logic [31:0] SERIAL_PRIO_OFFSET = 32'h0000_0000;
   localparam logic [31:0] CAPTURE_PRIO_OFFSET = 32'h0000_0004;

   // field positions (lsb of each 3-bit field)
   localparam int SER_EVENT_LSB = 4;
   localparam int SER_FAULT_LSB = 0;
   localparam int CAP_FIVE_LSB = 12;
   localparam int CAP_FOUR_LSB = 8;
   localparam int CAP_THREE_LSB = 4;

   // implemented bits of each register
   localparam logic [15:0] SERIAL_PRIO_MASK = 16'h0077;
   localparam logic [15:0] CAPTURE_PRIO_MASK = 16'h7770;

   // level codes
   localparam ipr_level_t LEVEL_OFF = 3'h0;
   localparam ipr_level_t LEVEL_LOWEST = 3'h1;
   localparam ipr_level_t LEVEL_RESET = 3'h4;
   localparam ipr_level_t LEVEL_HIGHEST = 3'h7;

   // reset values, every field at LEVEL_RESET
   localparam logic [15:0] SERIAL_PRIO_RESET = 16'h0044;
   localparam logic [15:0] CAPTURE_PRIO_RESET = 16'h4440;

   // ahb-lite codes
   localparam logic [2:0] HSIZE_BYTE = 3'h0;
   localparam logic [2:0] HSIZE_HALF = 3'h1;
   localparam logic [1:0] HRESP_OKAY = 2'h0;

endpackage

// ==== rtl/ipr_regs.sv ====
`timescale 1ns/1ns
// Overview of operation
// - a field holding 111 gives its source level 7, the highest, and each middle code its own level.
// - a field holding 001 gives level 1, the lowest enabled, and 000 disables the source.
// - the capture register holds the channel five level in bits 14 to 12.
// - every implemented field bit of both registers can be read and written by software.
// - the capture register holds the channel four level in bits 10 to 8.
module ipr_regs
   import ipr_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic clkEn,
   input wire logic hsel,
   input wire logic [ADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output ipr_levels_s levels,
   output logic [NUM_SOURCES-1:0] srcEnabled
);

   if (ADDR_W < 3 || ADDR_W > 32) begin : g_bad_addr_w
      $error("ipr_regs: ADDR_W must lie in 3..32");
   end

   ////////////////////////////////////////////////////////////////////////////
   // address phase decode

   logic addrPhase;
   logic [3:0] laneMask;
   logic [ADDR_W-1:0] wordAddr;

   assign addrPhase = hsel && htrans[1] && hready && clkEn;
   assign wordAddr = {haddr[ADDR_W-1:2], 2'b00};

   always_comb begin
      case (hsize)
         HSIZE_BYTE: laneMask = 4'h1 << haddr[1:0];
         HSIZE_HALF: laneMask = haddr[1] ? 4'hc : 4'h3;
         default: laneMask = 4'hf;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // write data phase bookkeeping

   logic wrPend_reg;
   logic [ADDR_W-1:0] wrAddr_reg;
   logic [3:0] wrLanes_reg;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         wrPend_reg <= 1'b0;
         wrAddr_reg <= '0;
         wrLanes_reg <= 4'h0;
      end else if (clkEn) begin
         wrPend_reg <= addrPhase && hwrite;
         if (addrPhase && hwrite) begin
            wrAddr_reg <= wordAddr;
            wrLanes_reg <= laneMask;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // priority registers

   logic [15:0] serialPortTwoPriority_reg;
   logic [15:0] captureChannelsPriority_reg;
   logic [15:0] serialPortTwoPriority_next;
   logic [15:0] captureChannelsPriority_next;
   logic wrSerial;
   logic wrCapture;

   // merge the enabled low byte lanes, drop unimplemented bits
   function automatic logic [15:0] mergeLanes(
      input logic [15:0] old,
      input logic [31:0] wdata,
      input logic [3:0] lanes,
      input logic [15:0] mask
   );
      logic [15:0] res;
      res = old;
      if (lanes[0]) begin
         res[7:0] = wdata[7:0];
      end
      if (lanes[1]) begin
         res[15:8] = wdata[15:8];
      end
      return res & mask;
   endfunction

   assign wrSerial = wrPend_reg &&
      wrAddr_reg == SERIAL_PRIO_OFFSET[ADDR_W-1:0];
   assign wrCapture = wrPend_reg &&
      wrAddr_reg == CAPTURE_PRIO_OFFSET[ADDR_W-1:0];

   always_comb begin
      serialPortTwoPriority_next = serialPortTwoPriority_reg;
      captureChannelsPriority_next = captureChannelsPriority_reg;
      if (wrSerial) begin
         serialPortTwoPriority_next = mergeLanes(serialPortTwoPriority_reg,
            hwdata, wrLanes_reg, SERIAL_PRIO_MASK);
      end
      if (wrCapture) begin
         captureChannelsPriority_next = mergeLanes(
            captureChannelsPriority_reg, hwdata, wrLanes_reg,
            CAPTURE_PRIO_MASK);
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         serialPortTwoPriority_reg <= SERIAL_PRIO_RESET;
         captureChannelsPriority_reg <= CAPTURE_PRIO_RESET;
      end else if (clkEn) begin
         serialPortTwoPriority_reg <= serialPortTwoPriority_next;
         captureChannelsPriority_reg <= captureChannelsPriority_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // level outputs and per-source enables

   ipr_levels_s levelsNext;
   logic [3*NUM_SOURCES-1:0] levelVecNext;

   // field code is the level itself: 7 highest, 1 lowest, 0 off
   always_comb begin
      levelsNext.serialEventLevel =
         serialPortTwoPriority_next[SER_EVENT_LSB +: 3];
      levelsNext.serialFaultLevel =
         serialPortTwoPriority_next[SER_FAULT_LSB +: 3];
      levelsNext.captureFiveLevel =
         captureChannelsPriority_next[CAP_FIVE_LSB +: 3];
      levelsNext.captureFourLevel =
         captureChannelsPriority_next[CAP_FOUR_LSB +: 3];
      levelsNext.captureThreeLevel =
         captureChannelsPriority_next[CAP_THREE_LSB +: 3];
   end

   assign levelVecNext = levelsNext;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         levels <= '{LEVEL_RESET, LEVEL_RESET, LEVEL_RESET, LEVEL_RESET,
            LEVEL_RESET};
      end else if (clkEn) begin
         levels <= levelsNext;
      end
   end

   for (genvar i = 0; i < NUM_SOURCES; i++) begin : g_enable
      always_ff @(posedge sys_clk or negedge arst_n) begin
         if (!arst_n) begin
            srcEnabled[i] <= 1'b1;
         end else if (clkEn) begin
            srcEnabled[i] <= levelVecNext[3*i +: 3] != LEVEL_OFF;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data and response

   logic [31:0] rdNext;

   // next values forward a write still in its data phase
   always_comb begin
      rdNext = 32'h0000_0000;
      if (wordAddr == SERIAL_PRIO_OFFSET[ADDR_W-1:0]) begin
         rdNext = {16'h0000, serialPortTwoPriority_next};
      end else if (wordAddr == CAPTURE_PRIO_OFFSET[ADDR_W-1:0]) begin
         rdNext = {16'h0000, captureChannelsPriority_next};
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         hrdata <= 32'h0000_0000;
      end else if (clkEn) begin
         hrdata <= (addrPhase && !hwrite) ? rdNext : 32'h0000_0000;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         hreadyout <= 1'b1;
         hresp <= HRESP_OKAY[0];
      end else if (clkEn) begin
         hreadyout <= 1'b1;
         hresp <= HRESP_OKAY[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   logic rdCapPend_reg;
   logic rdAnyPend_reg;
   logic postReset_reg;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rdCapPend_reg <= 1'b0;
         rdAnyPend_reg <= 1'b0;
         postReset_reg <= 1'b0;
      end else begin
         postReset_reg <= 1'b1;
         if (clkEn) begin
            rdAnyPend_reg <= addrPhase && !hwrite;
            rdCapPend_reg <= addrPhase && !hwrite &&
               wordAddr == CAPTURE_PRIO_OFFSET[ADDR_W-1:0];
         end
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   a_top_level_write: assert property (
      clkEn && wrSerial && wrLanes_reg[0] && hwdata[6:4] == 3'h7
      |=> levels.serialEventLevel == LEVEL_HIGHEST && srcEnabled[4])
      else $error("code 111 did not give level 7");

   a_zero_disables: assert property (
      clkEn && wrSerial && wrLanes_reg[0] && hwdata[2:0] == 3'h0
      |=> !srcEnabled[3] && levels.serialFaultLevel == LEVEL_OFF)
      else $error("code 000 left source enabled");

   a_one_lowest: assert property (
      clkEn && wrCapture && wrLanes_reg[0] && hwdata[6:4] == 3'h1
      |=> srcEnabled[0] && levels.captureThreeLevel == LEVEL_LOWEST)
      else $error("code 001 did not give enabled level 1");

   a_five_position: assert property (
      rdCapPend_reg |-> hrdata[14:12] == levels.captureFiveLevel)
      else $error("channel five level not at bits 14:12");

   a_four_position: assert property (
      rdCapPend_reg |-> hrdata[10:8] == levels.captureFourLevel)
      else $error("channel four level not at bits 10:8");

   a_write_readback: assert property (
      clkEn && wrSerial && wrLanes_reg[1:0] == 2'b11
      |=> serialPortTwoPriority_reg ==
         ($past(hwdata[15:0]) & SERIAL_PRIO_MASK))
      else $error("written field did not read back");

   a_reserved_zero: assert property (
      rdAnyPend_reg |-> hrdata[31:16] == 16'h0000 && hrdata[15] == 1'b0
         && hrdata[11] == 1'b0 && hrdata[7] == 1'b0 && hrdata[3] == 1'b0)
      else $error("unimplemented bit read nonzero");

   a_reset_default: assert property (
      !postReset_reg |-> serialPortTwoPriority_reg == SERIAL_PRIO_RESET
         && captureChannelsPriority_reg == CAPTURE_PRIO_RESET
         && levels.captureFourLevel == LEVEL_RESET)
      else $error("fields not at reset level after reset");

   a_unmapped_ignored: assert property (
      clkEn && wrPend_reg && !wrSerial && !wrCapture
      |=> $stable(serialPortTwoPriority_reg)
         && $stable(captureChannelsPriority_reg))
      else $error("write to unmapped word changed a register");

   a_unimpl_clear: assert property (
      (serialPortTwoPriority_reg & ~SERIAL_PRIO_MASK) == 16'h0000
         && (captureChannelsPriority_reg & ~CAPTURE_PRIO_MASK) == 16'h0000)
      else $error("unimplemented register bit set");

   a_levels_follow: assert property (
      levels.serialEventLevel ==
         serialPortTwoPriority_reg[SER_EVENT_LSB +: 3]
      && levels.serialFaultLevel ==
         serialPortTwoPriority_reg[SER_FAULT_LSB +: 3]
      && levels.captureFiveLevel ==
         captureChannelsPriority_reg[CAP_FIVE_LSB +: 3]
      && levels.captureFourLevel ==
         captureChannelsPriority_reg[CAP_FOUR_LSB +: 3]
      && levels.captureThreeLevel ==
         captureChannelsPriority_reg[CAP_THREE_LSB +: 3])
      else $error("level output differs from its register field");

   a_enable_follow: assert property (
      srcEnabled == {levels.serialEventLevel != LEVEL_OFF,
         levels.serialFaultLevel != LEVEL_OFF,
         levels.captureFiveLevel != LEVEL_OFF,
         levels.captureFourLevel != LEVEL_OFF,
         levels.captureThreeLevel != LEVEL_OFF})
      else $error("source enable differs from its level");

   c_serial_write: cover property (clkEn && wrSerial);
   c_capture_read: cover property (rdCapPend_reg);
   c_byte_write: cover property (clkEn && wrCapture && wrLanes_reg == 4'h2);
   c_half_write: cover property (clkEn && wrSerial && wrLanes_reg == 4'h3);
   c_source_off: cover property (srcEnabled != 5'h1f);

endmodule // ipr_regs

// ==== bench/interrupt_priority_regs_test.sv ====
`timescale 1ns/1ns
module interrupt_priority_regs_test
   import ipr_pkg::*;
;
   logic sys_clk = 1'b0;
   logic arst_n;
   logic clkEn;
   logic hsel;
   logic [7:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [2:0] hsize;
   logic [31:0] hwdata;
   logic hready;
   logic hresp;
   logic [31:0] hrdata;
   ipr_levels_s levels;
   logic [4:0] srcEnabled;
   int miscompares = 0;
   int n_tests = 0;
   int cycles = 0;
   logic [2:0] c;
   logic [15:0] serExp;
   logic [15:0] capExp;

   always #10 sys_clk = ~sys_clk;

   ipr_regs u_dut (
      .sys_clk(sys_clk), .arst_n(arst_n), .clkEn(clkEn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hreadyout(hready),
      .hresp(hresp), .hrdata(hrdata), .levels(levels),
      .srcEnabled(srcEnabled)
   );

   ////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // hang guard, tests take well under a thousand cycles
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         end_sim();
      end
   end

   task automatic chk_data(string what, logic [31:0] exp, logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_out(ipr_levels_s el, logic [4:0] ee);
      n_tests++;
      if (levels !== el || srcEnabled !== ee) begin
         miscompares++;
         $display("unexpected levels: expected %h/%h seen %h/%h",
            el, ee, levels, srcEnabled);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   // one single transfer, entered just after a rising edge
   task automatic xfer(logic [7:0] a, logic wr, logic [2:0] sz,
         logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      hsize <= sz;
      do @(posedge sys_clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge sys_clk); while (hready !== 1'b1);
      rd = hrdata;
      chk_data("hresp", 32'h0, {31'h0, hresp});
   endtask

   task automatic wr(logic [7:0] a, logic [2:0] sz, logic [31:0] wd);
      logic [31:0] rd;
      xfer(a, 1'b1, sz, wd, rd);
   endtask

   task automatic rdchk(string what, logic [7:0] a, logic [15:0] exp);
      logic [31:0] rd;
      xfer(a, 1'b0, 3'h2, 32'h0, rd);
      chk_data(what, {16'h0, exp}, rd);
   endtask

   task automatic do_reset();
      arst_n <= 1'b0;
      repeat (12) @(posedge sys_clk);
      arst_n <= 1'b1;
      @(posedge sys_clk);
   endtask

   // both registers and outputs at their defaults
   task automatic chk_defaults();
      chk_out('{3'h4, 3'h4, 3'h4, 3'h4, 3'h4}, 5'h1f);
      rdchk("serial reset", 8'h00, 16'h0044);
      rdchk("capture reset", 8'h04, 16'h4440);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      arst_n = 1'b0;
      clkEn = 1'b1;
      hsel = 1'b0;
      haddr = 8'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      do_reset();
      chk_defaults();
      $display("test reset values done");

      // every code in every field, unimplemented bits written as ones
      for (int i = 0; i < 8; i++) begin
         c = i[2:0];
         serExp = {9'h0, c, 1'b0, ~c};
         capExp = {1'b0, c, 1'b0, c + 3'h1, 1'b0, ~c, 4'h0};
         wr(8'h00, 3'h2, {16'hffff, serExp | ~SERIAL_PRIO_MASK});
         wr(8'h04, 3'h2, {16'hffff, capExp | ~CAPTURE_PRIO_MASK});
         @(posedge sys_clk);
         chk_out('{c, ~c, c, c + 3'h1, ~c},
            {c != 0, c != 7, c != 0, c != 7, c != 7});
         rdchk("serial field", 8'h00, serExp);
         rdchk("capture field", 8'h04, capExp);
      end
      $display("test level codes done");

      // byte lanes of the capture register, lane one then lane zero
      wr(8'h05, HSIZE_BYTE, 32'h0000_12ff);
      wr(8'h04, HSIZE_BYTE, 32'h0000_ff5f);
      @(posedge sys_clk);
      chk_out('{3'h7, 3'h0, 3'h1, 3'h2, 3'h5}, 5'h17);
      rdchk("capture bytes", 8'h04, 16'h1250);
      $display("test byte lanes done");

      // unmapped word: reads zero, write lands nowhere
      wr(8'h08, 3'h2, 32'hffff_ffff);
      rdchk("unmapped", 8'h08, 16'h0000);
      rdchk("serial kept", 8'h00, 16'h0070);
      rdchk("capture kept", 8'h04, 16'h1250);
      $display("test unmapped done");

      // halfword lanes: upper half ignored, lower half lands
      wr(8'h06, HSIZE_HALF, 32'h7777_0000);
      wr(8'h00, HSIZE_HALF, 32'h0000_ff35);
      @(posedge sys_clk);
      chk_out('{3'h3, 3'h5, 3'h1, 3'h2, 3'h5}, 5'h1f);
      rdchk("serial half", 8'h00, 16'h0035);
      rdchk("capture upper half", 8'h04, 16'h1250);
      $display("test halfword lanes done");

      // no transfer is taken while the clock enable is low
      clkEn <= 1'b0;
      wr(8'h00, 3'h2, 32'h0000_0000);
      clkEn <= 1'b1;
      rdchk("serial frozen", 8'h00, 16'h0035);
      $display("test clock enable done");

      // reset in mid-run brings every field back to 100
      do_reset();
      chk_defaults();
      $display("test second reset done");
      end_sim();
   end
endmodule // interrupt_priority_regs_test
